// ---- core/tio_map.svh ----
// Register map, field layout and reset values of the timed I/O port block
`ifndef TIO_MAP_SVH
`define TIO_MAP_SVH
`define TIO_NPORT 5
`define TIO_NCB 6
`define TIO_WORD 32
`define TIO_UNIT_MSB 6
`define TIO_UNIT_LSB 4
`define TIO_IDX_MSB 3
`define TIO_U_SYS 3'h5
`define TIO_R_CTRL 4'h0
`define TIO_R_DATA 4'h1
`define TIO_R_TIME 4'h2
`define TIO_R_STAMP 4'h3
`define TIO_R_COND 4'h4
`define TIO_R_STAT 4'h5
`define TIO_R_LINK 4'h6
`define TIO_R_PINS 4'h7
`define TIO_CTRL_BITS 9
`define TIO_CB_BITS 9
`define TIO_CTRL_RST 9'h000
`define TIO_CB_RST 9'h000
`define TIO_COND_EQ 2'h1
`define TIO_COND_NE 2'h2
`define TIO_LINK_LO 16
`endif

// ---- core/tio_pkg.sv ----
// Types shared by the timed I/O port block
package tio_pkg;
  typedef struct packed {
    logic en;
    logic out;
    logic od;
    logic strb_en;
    logic [1:0] cond;
    logic [2:0] clk_sel;
  } tio_ctrl_t;

  typedef struct packed {
    logic ext;
    logic [7:0] div;
  } tio_cb_t;

  typedef struct packed {
    logic busy;
    logic timed;
    logic pend;
    logic valid;
  } tio_stat_t;

  typedef enum logic [2:0] {
    TIO_IDLE = 3'h1,
    TIO_ARMED = 3'h2,
    TIO_SHIFT = 3'h4
  } tio_pst_t;

  function automatic int tio_pw(input int k);
    case (k)
      0: return 1;
      1: return 4;
      2: return 8;
      3: return 16;
      default: return 32;
    endcase
  endfunction
endpackage

// ---- core/tio_clkblk.sv ----
// One clock block: reference or external pin source, optional divider
`timescale 1ns/100ps
`default_nettype none
module tio_clkblk (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ext_i,
  input wire tio_pkg::tio_cb_t cfg_i,
  output logic tick_o
);
  logic ext_d_ff;
  logic tick_ff;
  logic [7:0] dcnt_ff;
  logic src;

  // Input is already synchronised; this flop only finds the rising edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ext_d_ff <= 1'b0;
    end else begin
      ext_d_ff <= ext_i;
    end
  end

  assign src = cfg_i.ext ? (ext_i && !ext_d_ff) : 1'b1;

  // Divide by div+1; div of zero passes every source edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      dcnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else if (src && dcnt_ff >= cfg_i.div) begin
      dcnt_ff <= 8'h00;
      tick_ff <= 1'b1;
    end else begin
      dcnt_ff <= src ? 8'(dcnt_ff + 8'h01) : dcnt_ff;
      tick_ff <= 1'b0;
    end
  end

  assign tick_o = tick_ff;
endmodule
`default_nettype wire

// ---- core/tio_port.sv ----
// One timed port: counter, serializer, transfer register, condition
`timescale 1ns/100ps
`default_nettype none
`include "tio_map.svh"
module tio_port #(
  parameter int W = 1,
  parameter int WORD = 32
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire tio_pkg::tio_ctrl_t ctrl_i,
  input wire logic [W-1:0] cond_i,
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [WORD-1:0] wdata_i,
  input wire logic time_wr_i,
  input wire logic [15:0] time_i,
  input wire logic strobe_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] pin_o,
  output logic [W-1:0] pin_oe_o,
  output logic strobe_o,
  output logic [WORD-1:0] data_o,
  output logic [15:0] cnt_o,
  output logic [15:0] stamp_o,
  output tio_pkg::tio_stat_t stat_o,
  output logic event_o
);
  localparam int SAMP = WORD / W;
  tio_pkg::tio_pst_t st_ff;
  logic [15:0] cnt_ff, time_ff, stamp_ff;
  logic timed_ff, pend_ff, valid_ff, strb_ff, drv_ff;
  logic [WORD-1:0] xfer_ff, sh_ff, data_ff, src, out_nxt, in_nxt;
  logic [W-1:0] pin_ff;
  logic [5:0] left_ff;
  logic hit, cond_ok, strb_ok, start, step, done;

  assign hit = !timed_ff || cnt_ff == time_ff;

  always_comb begin
    case (ctrl_i.cond)
      `TIO_COND_EQ: cond_ok = pin_i == cond_i;
      `TIO_COND_NE: cond_ok = pin_i != cond_i;
      default: cond_ok = 1'b1;
    endcase
  end

  assign strb_ok = !ctrl_i.strb_en || strobe_i;
  assign start = tick_i && st_ff == tio_pkg::TIO_ARMED && hit &&
                 (ctrl_i.out ? pend_ff : (cond_ok && strb_ok));
  assign step = tick_i && st_ff == tio_pkg::TIO_SHIFT &&
                (ctrl_i.out || strb_ok);
  assign done = (start && SAMP == 1) || (step && left_ff == 6'h01);
  assign src = start ? (ctrl_i.out ? xfer_ff : '0) : sh_ff;

  // Always full width, even when some pins belong to a narrower port
  generate
    if (W == WORD) begin : g_full
      assign out_nxt = '0;
      assign in_nxt = pin_i;
    end else begin : g_part
      assign out_nxt = {{W{1'b0}}, src[WORD-1:W]};
      assign in_nxt = {pin_i, src[WORD-1:W]};
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_ff <= tio_pkg::TIO_IDLE;
    end else begin
      unique case (st_ff)
        tio_pkg::TIO_IDLE: begin
          if (ctrl_i.en) begin
            st_ff <= tio_pkg::TIO_ARMED;
          end
        end
        tio_pkg::TIO_ARMED: begin
          if (!ctrl_i.en) begin
            st_ff <= tio_pkg::TIO_IDLE;
          end else if (start && !done) begin
            st_ff <= tio_pkg::TIO_SHIFT;
          end
        end
        tio_pkg::TIO_SHIFT: begin
          if (!ctrl_i.en) begin
            st_ff <= tio_pkg::TIO_IDLE;
          end else if (done) begin
            st_ff <= tio_pkg::TIO_ARMED;
          end
        end
        default: st_ff <= tio_pkg::TIO_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_ff <= 16'h0000;
    end else if (tick_i) begin
      cnt_ff <= 16'(cnt_ff + 16'h0001);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      timed_ff <= 1'b0;
      time_ff <= 16'h0000;
    end else if (time_wr_i) begin
      timed_ff <= 1'b1;
      time_ff <= time_i;
    end else if (start) begin
      timed_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      stamp_ff <= 16'h0000;
    end else if (start) begin
      stamp_ff <= cnt_ff;
    end
  end

  // A new word overwrites an unsent one; no queue beyond one word
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pend_ff <= 1'b0;
      xfer_ff <= '0;
    end else if (data_wr_i) begin
      pend_ff <= 1'b1;
      xfer_ff <= wdata_i;
    end else if (start && ctrl_i.out) begin
      pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sh_ff <= '0;
      left_ff <= 6'h00;
    end else if (start || step) begin
      sh_ff <= ctrl_i.out ? out_nxt : in_nxt;
      left_ff <= start ? 6'(SAMP - 1) : 6'(left_ff - 6'h01);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_ff <= '0;
    end else if ((start || step) && ctrl_i.out) begin
      pin_ff <= src[W-1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      drv_ff <= 1'b0;
    end else begin
      drv_ff <= ctrl_i.en && ctrl_i.out;
    end
  end

  // Completion wins over a read in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      valid_ff <= 1'b0;
      data_ff <= '0;
    end else if (done && !ctrl_i.out) begin
      valid_ff <= 1'b1;
      data_ff <= in_nxt;
    end else if (data_rd_i) begin
      valid_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      strb_ff <= 1'b0;
    end else if (tick_i) begin
      strb_ff <= (start || step) && ctrl_i.out;
    end
  end

  assign pin_o = ctrl_i.od ? '0 : pin_ff;
  assign pin_oe_o = drv_ff ? (ctrl_i.od ? ~pin_ff : '1) : '0;
  assign strobe_o = strb_ff;
  assign data_o = data_ff;
  assign cnt_o = cnt_ff;
  assign stamp_o = stamp_ff;
  // One driver for the whole status word
  assign stat_o = {st_ff != tio_pkg::TIO_IDLE, timed_ff, pend_ff, valid_ff};
  assign event_o = ctrl_i.out ? (ctrl_i.en && !pend_ff) : valid_ff;
endmodule
`default_nettype wire

// ---- core/tio_top.sv ----
// Timed I/O ports, clock blocks, pin sharing and register access
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tio_map.svh"
module tio_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [31:0] pin_i,
  output logic [31:0] pin_o,
  output logic [31:0] pin_oe_o,
  output logic [31:0] pin_pd_o,
  input wire logic [`TIO_NPORT-1:0] input_strobe_i,
  output logic [`TIO_NPORT-1:0] output_strobe_o,
  output logic [`TIO_NPORT-1:0] event_o
);
  localparam int NP = `TIO_NPORT;
  localparam int NCB = `TIO_NCB;

  logic [31:0] pin_m_ff, pin_s_ff;
  logic [NP-1:0] stb_m_ff, stb_s_ff;
  tio_pkg::tio_ctrl_t ctrl_ff [NP];
  logic [31:0] cond_ff [NP];
  tio_pkg::tio_cb_t cb_ff [NCB];
  logic link_ff;
  logic [31:0] rdata_ff, nxt_rdata, pd_ff;
  logic [2:0] unit;
  logic [3:0] idx;
  logic [NCB-1:0] cb_tick;
  logic [NP-1:0] tick, psel;
  logic [31:0] po [NP];
  logic [31:0] poe [NP];
  logic [31:0] pdata [NP];
  logic [15:0] pcnt [NP];
  logic [15:0] pstamp [NP];
  tio_pkg::tio_stat_t pstat [NP];

  assign unit = addr_i[`TIO_UNIT_MSB:`TIO_UNIT_LSB];
  assign idx = addr_i[`TIO_IDX_MSB:0];

  // Pins and strobes come from outside; two flops before any use
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_m_ff <= 32'h00000000;
      pin_s_ff <= 32'h00000000;
      stb_m_ff <= '0;
      stb_s_ff <= '0;
    end else begin
      pin_m_ff <= pin_i;
      pin_s_ff <= pin_m_ff;
      stb_m_ff <= input_strobe_i;
      stb_s_ff <= stb_m_ff;
    end
  end

  // Port control and condition registers
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NP; k++) begin
        ctrl_ff[k] <= `TIO_CTRL_RST;
      end
    end else if (wr_i && idx == `TIO_R_CTRL) begin
      for (int k = 0; k < NP; k++) begin
        if (unit == 3'(k)) begin
          ctrl_ff[k] <= tio_pkg::tio_ctrl_t'(wdata_i[`TIO_CTRL_BITS-1:0]);
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int k = 0; k < NP; k++) begin
        cond_ff[k] <= 32'h00000000;
      end
    end else if (wr_i && idx == `TIO_R_COND) begin
      for (int k = 0; k < NP; k++) begin
        if (unit == 3'(k)) begin
          cond_ff[k] <= wdata_i;
        end
      end
    end
  end

  // Block 0 is the fixed reference; its register ignores writes
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NCB; c++) begin
        cb_ff[c] <= `TIO_CB_RST;
      end
    end else if (wr_i && unit == `TIO_U_SYS) begin
      for (int c = 1; c < NCB; c++) begin
        if (idx == 4'(c)) begin
          cb_ff[c] <= tio_pkg::tio_cb_t'(wdata_i[`TIO_CB_BITS-1:0]);
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      link_ff <= 1'b0;
    end else if (wr_i && unit == `TIO_U_SYS && idx == `TIO_R_LINK) begin
      link_ff <= wdata_i[0];
    end
  end

  generate
    for (genvar c = 0; c < NCB; c++) begin : g_cb
      tio_clkblk u_cb (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ext_i(pin_s_ff[0]),
        .cfg_i(cb_ff[c]),
        .tick_o(cb_tick[c])
      );
    end
  endgenerate

  // Out-of-range selection falls back to the reference block
  always_comb begin
    for (int k = 0; k < NP; k++) begin
      tick[k] = cb_tick[0];
      for (int c = 1; c < NCB; c++) begin
        if (ctrl_ff[k].clk_sel == 3'(c)) begin
          tick[k] = cb_tick[c];
        end
      end
    end
  end

  generate
    for (genvar k = 0; k < NP; k++) begin : g_port
      localparam int W = tio_pkg::tio_pw(k);
      logic [W-1:0] po_w, oe_w;
      assign psel[k] = unit == 3'(k);
      tio_port #(
        .W(W),
        .WORD(`TIO_WORD)
      ) u_port (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .tick_i(tick[k]),
        .ctrl_i(ctrl_ff[k]),
        .cond_i(cond_ff[k][W-1:0]),
        .data_wr_i(wr_i && psel[k] && idx == `TIO_R_DATA),
        .data_rd_i(rd_i && psel[k] && idx == `TIO_R_DATA),
        .wdata_i(wdata_i),
        .time_wr_i(wr_i && psel[k] && idx == `TIO_R_TIME),
        .time_i(wdata_i[15:0]),
        .strobe_i(stb_s_ff[k]),
        .pin_i(pin_s_ff[W-1:0]),
        .pin_o(po_w),
        .pin_oe_o(oe_w),
        .strobe_o(output_strobe_o[k]),
        .data_o(pdata[k]),
        .cnt_o(pcnt[k]),
        .stamp_o(pstamp[k]),
        .stat_o(pstat[k]),
        .event_o(event_o[k])
      );
      assign po[k] = 32'(po_w);
      assign poe[k] = 32'(oe_w);
    end
  endgenerate

  // Walk wide to narrow so the narrowest enabled port owns each pin
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      pin_o[i] = 1'b0;
      pin_oe_o[i] = 1'b0;
      for (int k = NP - 1; k >= 0; k--) begin
        if (ctrl_ff[k].en && i < tio_pkg::tio_pw(k)) begin
          pin_o[i] = po[k][i];
          pin_oe_o[i] = poe[k][i];
        end
      end
      if (link_ff && i >= `TIO_LINK_LO) begin
        pin_o[i] = 1'b0;
        pin_oe_o[i] = 1'b0;
      end
    end
  end

  // Pull-downs on every pin in reset, later only on undriven pins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pd_ff <= 32'hFFFFFFFF;
    end else begin
      pd_ff <= ~pin_oe_o;
    end
  end

  assign pin_pd_o = rst_i ? 32'hFFFFFFFF : pd_ff;

  always_comb begin
    nxt_rdata = 32'h00000000;
    for (int k = 0; k < NP; k++) begin
      if (unit == 3'(k)) begin
        case (idx)
          `TIO_R_CTRL: nxt_rdata = 32'(ctrl_ff[k]);
          `TIO_R_DATA: nxt_rdata = pdata[k];
          `TIO_R_TIME: nxt_rdata = 32'(pcnt[k]);
          `TIO_R_STAMP: nxt_rdata = 32'(pstamp[k]);
          `TIO_R_COND: nxt_rdata = cond_ff[k];
          `TIO_R_STAT: nxt_rdata = 32'(pstat[k]);
          default: nxt_rdata = 32'h00000000;
        endcase
      end
    end
    if (unit == `TIO_U_SYS) begin
      for (int c = 0; c < NCB; c++) begin
        if (idx == 4'(c)) begin
          nxt_rdata = 32'(cb_ff[c]);
        end
      end
      if (idx == `TIO_R_LINK) begin
        nxt_rdata = 32'(link_ff);
      end else if (idx == `TIO_R_PINS) begin
        nxt_rdata = pin_s_ff;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h00000000;
    end else begin
      rdata_ff <= rd_i ? nxt_rdata : 32'h00000000;
    end
  end

  assign rdata_o = rdata_ff;
endmodule
`default_nettype wire

// ---- sim/tio_checker.sv ----
// Port-level assertions for the timed I/O port block
`timescale 1ns/100ps
`default_nettype none
`include "tio_map.svh"
module tio_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic [31:0] pin_i,
  input wire logic [31:0] pin_o,
  input wire logic [31:0] pin_oe_o,
  input wire logic [31:0] pin_pd_o,
  input wire logic [`TIO_NPORT-1:0] input_strobe_i,
  input wire logic [`TIO_NPORT-1:0] output_strobe_o,
  input wire logic [`TIO_NPORT-1:0] event_o
);
  logic link_ff;
  logic [4:0] od_seen_ff;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      link_ff <= 1'b0;
    end else if (wr_i && addr_i[6:0] == 7'h56) begin
      link_ff <= wdata_i[0];
    end
  end
  // Sticky: once od is set on port 3 or 4, the split checks on its pins stay off
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      od_seen_ff <= 5'h00;
    end else if (wr_i && addr_i[3:0] == 4'h0 && addr_i[6:4] < 3'h5) begin
      od_seen_ff[addr_i[6:4]] <= od_seen_ff[addr_i[6:4]] | wdata_i[6];
    end
  end
  a_pd_release: assert property ($fell(rst_i) |-> pin_pd_o == 32'hFFFFFFFF)
    else $error("pull-downs not all on at reset release");
  a_pd_follows_oe: assert property (!$past(rst_i)
    |-> pin_pd_o == ~$past(pin_oe_o))
    else $error("pull-down does not follow drive enable");
  a_quiet_release: assert property ($fell(rst_i) |-> pin_oe_o == 32'h0
    && output_strobe_o == 5'h00 && event_o == 5'h00)
    else $error("outputs active right after reset");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data without a read");
  a_unmapped_zero: assert property (rd_i && addr_i[6:5] == 2'h3
    |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_cb0_fixed: assert property (rd_i && addr_i[6:0] == 7'h50
    |=> rdata_o == 32'h0)
    else $error("clock block 0 config not fixed");
  a_link_release: assert property (link_ff |-> pin_oe_o[31:16] == 16'h0)
    else $error("pins driven under enabled link");
  a_oe_upper_one: assert property (!od_seen_ff[4]
    |-> pin_oe_o[31:16] == 16'h0 || pin_oe_o[31:16] == 16'hFFFF)
    else $error("wide port pins split in direction");
  a_oe_mid_one: assert property (od_seen_ff[4:3] == 2'h0
    |-> pin_oe_o[15:8] == 8'h00 || pin_oe_o[15:8] == 8'hFF)
    else $error("shared pins split in direction");
  c_read: cover property (rd_i ##1 rdata_o != 32'h0);
  c_link: cover property (link_ff && pin_oe_o[7:0] != 8'h00);
  c_ostrobe: cover property (output_strobe_o[2]);
  c_event: cover property (event_o[0]);
endmodule
`default_nettype wire

// ---- sim/tio_pins_model.sv ----
// Pin-side model: wire levels, pull-downs and strobe source
`timescale 1ns/100ps
`default_nettype none
module tio_pins_model (
  input wire logic [31:0] pin_o_i,
  input wire logic [31:0] pin_oe_i,
  input wire logic [31:0] pin_pd_i,
  input wire logic [31:0] drv_i,
  input wire logic [31:0] drv_en_i,
  input wire logic [4:0] stb_req_i,
  output logic [31:0] wire_o,
  output logic [4:0] strobe_o
);
  // Device wins a clash; undriven pins fall to their pull-down level
  assign wire_o = (pin_oe_i & pin_o_i)
    | (~pin_oe_i & drv_en_i & drv_i)
    | (~pin_oe_i & ~drv_en_i & ~pin_pd_i);
  assign strobe_o = stb_req_i;
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the timed I/O port block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic mclk_i, rst_i, wr_i, rd_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i, rdata_o, pin_i, pin_o, pin_oe_o, pin_pd_o;
  logic [31:0] drv, drv_en, v, c0;
  logic [15:0] d;
  logic [4:0] stb_req, input_strobe_i, output_strobe_o, event_o;
  int error_cnt, checked, n;
  tio_top dut_u (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .pin_i, .pin_o, .pin_oe_o, .pin_pd_o, .input_strobe_i,
    .output_strobe_o, .event_o);
  tio_pins_model pm_u (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
    .pin_pd_i(pin_pd_o), .drv_i(drv), .drv_en_i(drv_en),
    .stb_req_i(stb_req), .wire_o(pin_i), .strobe_o(input_strobe_i));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic summarize;
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= w;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    r = rdata_o;
  endtask
  // Bounded wait for a byte on the 8-bit port
  task automatic wpin(input logic [7:0] x);
    for (n = 0; n < 100 && pin_o[7:0] !== x; n++) tk(1);
    chk("first_byte", pin_o[7:0], x);
  endtask
  task automatic t_reset;
    chk("pd_reset", pin_pd_o, 32'hFFFFFFFF);
    rd(8'h20, v);
    chk("ctrl_rst", v, 32'h0);
  endtask
  task automatic t_serial;
    wr(8'h20, 32'h180);
    wr(8'h21, 32'h44332211);
    wpin(8'h11);
    chk("oe8", pin_oe_o[7:0], 8'hFF);
    chk("ostb", output_strobe_o[2], 1'b1);
    for (int i = 2; i < 5; i++) begin
      tk(1);
      chk("byte", pin_o[7:0], 32'h11 * i);
    end
    tk(2);
    chk("evt_out", event_o[2], 1'b1);
  endtask
  task automatic t_od;
    wr(8'h20, 32'h1C0);
    wr(8'h21, 32'h000000F0);
    for (n = 0; n < 100 && pin_oe_o[7:0] !== 8'h0F; n++) tk(1);
    chk("od_oe", pin_oe_o[7:0], 8'h0F);
    chk("od_lo", pin_o[7:0] & pin_oe_o[7:0], 8'h00);
    tk(4);
    chk("od_zero", pin_oe_o[7:0], 8'hFF);
    wr(8'h20, 32'h180);
  endtask
  task automatic t_timed;
    rd(8'h22, c0);
    rd(8'h22, v);
    d = v[15:0] - c0[15:0];
    chk("cnt_step", d, 16'h2);
    d = v[15:0] + 16'h28;
    wr(8'h22, {16'h0, d});
    wr(8'h21, 32'h000000A5);
    wpin(8'hA5);
    chk("late", n > 30, 1'b1);
    rd(8'h23, v);
    chk("stamp", v, {16'h0, d});
  endtask
  task automatic t_input;
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h128);
    drv_en <= 32'h1;
    stb_req <= 5'h01;
    tk(1);
    chk("share", pin_oe_o[7:0], 8'hFE);
    tk(40);
    chk("cond", event_o[0], 1'b0);
    @(posedge mclk_i);
    stb_req <= 5'h00;
    drv <= 32'h1;
    tk(40);
    chk("gate", event_o[0], 1'b0);
    @(posedge mclk_i);
    stb_req <= 5'h01;
    for (n = 0; n < 100 && event_o[0] !== 1'b1; n++) tk(1);
    rd(8'h01, v);
    chk("word", v, 32'hFFFFFFFF);
    chk("evt_clr", event_o[0], 1'b0);
    wr(8'h00, 32'h0);
    drv_en <= 32'h0;
  endtask
  task automatic t_link;
    wr(8'h40, 32'h180);
    wr(8'h41, 32'hFFFF0000);
    tk(10);
    chk("wide", pin_oe_o[31:8], 24'hFFFFFF);
    wr(8'h56, 32'h1);
    tk(1);
    chk("link", pin_oe_o[31:16], 16'h0);
    rd(8'h56, v);
    chk("link_rd", v, 32'h1);
    wr(8'h7A, 32'hFFFFFFFF);
    rd(8'h7A, v);
    chk("unmapped", v, 32'h0);
  endtask
  task automatic t_clkblk;
    wr(8'h51, 32'h3);
    wr(8'h30, 32'h1);
    rd(8'h32, c0);
    tk(6);
    rd(8'h32, v);
    d = v[15:0] - c0[15:0];
    chk("div", d, 16'h2);
    wr(8'h50, 32'h1FF);
    rd(8'h50, v);
    chk("cb0", v, 32'h0);
  endtask
  // Pin 0 as clock source, divided by two; pin 0 must be released first
  task automatic t_extclk;
    wr(8'h20, 32'h0);
    wr(8'h40, 32'h0);
    drv <= 32'h0;
    drv_en <= 32'h1;
    wr(8'h52, 32'h101);
    wr(8'h30, 32'h2);
    rd(8'h32, c0);
    repeat (4) begin
      drv <= 32'h1;
      tk(3);
      drv <= 32'h0;
      tk(3);
    end
    tk(4);
    rd(8'h32, v);
    d = v[15:0] - c0[15:0];
    chk("ext_div", d, 16'h2);
    drv_en <= 32'h0;
  endtask
  initial begin
    error_cnt = 0;
    checked = 0;
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    drv = 32'h0;
    drv_en = 32'h0;
    stb_req = 5'h00;
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    tk(1);
    t_reset;
    t_serial;
    t_od;
    t_timed;
    t_input;
    t_link;
    t_clkblk;
    t_extclk;
    summarize;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge mclk_i);
    error_cnt++;
    summarize;
  end
endmodule
bind tio_top tio_checker chk_u (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .pin_i, .pin_o, .pin_oe_o, .pin_pd_o, .input_strobe_i,
  .output_strobe_o, .event_o);
`default_nettype wire
